// *** sim/mgmt_host.sv ***
// Station management host model issuing decoded register requests.
// Assumes the bank samples requests on the rising edge of i_clk.
`timescale 1ns/100ps
`default_nettype none

module mgmt_host (
    // Clock
    input  wire logic                   i_clk,
    // Request toward the bank
    output var wake_regs_pkg::reg_req_t o_req
);
    initial o_req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // One request held for one rising edge, then released
    task automatic send(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] data,
                        input logic wr);
        @(negedge i_clk);
        o_req.device   = dev;
        o_req.reg_addr = addr;
        o_req.wdata    = data;
        o_req.write    = wr;
        o_req.read     = !wr;
        @(negedge i_clk);
        o_req.write    = 1'b0;
        o_req.read     = 1'b0;
        o_req.wdata    = ~data;
        o_req.reg_addr = ~addr;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Write (with a read in the same cycle when both is set), then read of the same word in the next cycle
    task automatic send_wr_rd(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] data,
                              input logic both);
        @(negedge i_clk);
        o_req.device   = dev;
        o_req.reg_addr = addr;
        o_req.wdata    = data;
        o_req.write    = 1'b1;
        o_req.read     = both;
        @(negedge i_clk);
        o_req.write    = 1'b0;
        o_req.read     = 1'b1;
        o_req.wdata    = ~data;
        @(negedge i_clk);
        o_req.read     = 1'b0;
        o_req.reg_addr = ~addr;
    endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the wake event register bank.
// Assumes the host model drives all requests at the falling edge.
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic                         i_clk;
    logic                         i_resetn;
    wake_regs_pkg::reg_req_t      req;
    logic                         o_rd_valid;
    logic [15:0]                  o_rd_data;
    wake_regs_pkg::wake_enable_t  o_enables;
    logic [47:0]                  o_dest_addr;
    int                           failures;
    int                           tests_run;
    int                           cycles;

    mgmt_host host (.i_clk(i_clk), .o_req(req));

    wol_event_enable_regs dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_enables(o_enables), .o_dest_addr(o_dest_addr)
    );

    initial i_clk = 1'b0;
    always #50 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Checks and access tasks
    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] data);
        host.send(dev, addr, data, 1'b1);
    endtask

    task automatic rd(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] exp);
        host.send(dev, addr, 16'h0000, 1'b0);
        chk("rd_valid", 48'h000000000001, {47'h0, o_rd_valid});
        chk("rd_data", {32'h0, exp}, {32'h0, o_rd_data});
    endtask

    function automatic wake_regs_pkg::wake_enable_t en_of(input logic [15:0] c);
        en_of = {c[wake_regs_pkg::BIT_REMOTE_FRAME], c[wake_regs_pkg::BIT_CUSTOM2],
                 c[wake_regs_pkg::BIT_CUSTOM1], c[wake_regs_pkg::BIT_CUSTOM0],
                 c[wake_regs_pkg::BIT_LINK_DOWN], c[wake_regs_pkg::BIT_LINK_UP]};
    endfunction

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        failures = 0;
        tests_run = 0;
        cycles = 0;
        i_resetn = 1'b0;
        repeat (8) @(negedge i_clk);
        i_resetn = 1'b1;
        chk("enables", 48'h0, {42'h0, o_enables});
        chk("dest_addr", 48'h0, o_dest_addr);
        for (int a = 16; a < 20; a++) begin
            rd(5'h02, 16'(a), 16'h0000);
        end
        for (int b = 0; b < 7; b++) begin
            if (b == 5) continue;
            wr(5'h02, 16'h0010, 16'h0001 << b);
            chk("enables", {42'h0, en_of(16'h0001 << b)}, {42'h0, o_enables});
            rd(5'h02, 16'h0010, 16'h0001 << b);
        end
        wr(5'h02, 16'h0010, 16'hFFA0);
        chk("enables", 48'h0, {42'h0, o_enables});
        rd(5'h02, 16'h0010, 16'hFFA0);
        wr(5'h02, 16'h0010, 16'h005F);
        chk("enables", 48'h00000000003F, {42'h0, o_enables});
        wr(5'h03, 16'h0010, 16'h0000);
        wr(5'h02, 16'h0014, 16'h0000);
        chk("enables", 48'h00000000003F, {42'h0, o_enables});
        rd(5'h02, 16'h0014, 16'h0000);
        wr(5'h02, 16'h0011, 16'hE5F6);
        wr(5'h02, 16'h0012, 16'hC3D4);
        wr(5'h02, 16'h0013, 16'hA1B2);
        chk("dest_addr", 48'hA1B2C3D4E5F6, o_dest_addr);
        rd(5'h02, 16'h0011, 16'hE5F6);
        rd(5'h02, 16'h0012, 16'hC3D4);
        rd(5'h02, 16'h0013, 16'hA1B2);
        wr(5'h02, 16'h0012, 16'h0000);
        chk("dest_addr", 48'hA1B20000E5F6, o_dest_addr);
        host.send_wr_rd(5'h02, 16'h0011, 16'h5A5A, 1'b1);
        chk("rd_valid", 48'h000000000001, {47'h0, o_rd_valid});
        chk("rd_data", 48'h000000005A5A, {32'h0, o_rd_data});
        chk("dest_addr", 48'hA1B200005A5A, o_dest_addr);
        rd(5'h03, 16'h0010, 16'h0000);
        @(negedge i_clk);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'b1;
        chk("enables", 48'h0, {42'h0, o_enables});
        chk("dest_addr", 48'h0, o_dest_addr);
        rd(5'h02, 16'h0010, 16'h0000);
        give_verdict();
    end
endmodule

`default_nettype wire

// *** verilog/wake_regs_pkg.sv ***
// Constants and carrier types for the wake-event register bank.
// Assumes the management register logic supplies device/register decode.
package wake_regs_pkg;

    // Indirect management device space location
    localparam logic [4:0]  WAKE_DEVICE_ADDR  = 5'h02;
    localparam logic [15:0] OFF_EVENT_CONTROL = 16'h0010;
    localparam logic [15:0] OFF_ADDR_LOW      = 16'h0011;
    localparam logic [15:0] OFF_ADDR_MID      = 16'h0012;
    localparam logic [15:0] OFF_ADDR_HIGH     = 16'h0013;

    // Reset values
    localparam logic [15:0] RESET_EVENT_CONTROL = 16'h0000;
    localparam logic [15:0] RESET_ADDR_WORD     = 16'h0000;
    localparam logic [15:0] RESET_READ_DATA     = 16'h0000;

    // Event control field positions
    localparam int BIT_LINK_UP      = 0;
    localparam int BIT_LINK_DOWN    = 1;
    localparam int BIT_CUSTOM0      = 2;
    localparam int BIT_CUSTOM1      = 3;
    localparam int BIT_CUSTOM2      = 4;
    localparam int BIT_REMOTE_FRAME = 6;

    // Register access request
    typedef struct packed {
        logic [4:0]  device;
        logic [15:0] reg_addr;
        logic        write;
        logic        read;
        logic [15:0] wdata;
    } reg_req_t;

    // Enables toward the frame-matching logic
    typedef struct packed {
        logic remote_frame;
        logic custom2;
        logic custom1;
        logic custom0;
        logic link_down;
        logic link_up;
    } wake_enable_t;

endpackage

// *** verilog/wake_word_reg.sv ***
// One 16-bit read/write configuration word.
// Assumes a single-cycle write strobe on the management clock.
`timescale 1ns/100ps
`default_nettype none

module wake_word_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Write port
    input  wire logic        i_wr_en,
    input  wire logic [15:0] i_wr_data,
    // Stored word
    output logic      [15:0] o_word
);

    typedef struct packed {
        logic [15:0] word;
    } word_state_t;

    word_state_t state_reg;
    word_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (i_wr_en) begin
            state_next.word = i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg.word <= RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_word = state_reg.word;

endmodule

`default_nettype wire

// *** verilog/wol_event_enable_regs.sv ***
// Wake event enable and destination address registers.
// Assumes register requests arrive already decoded from the serial management
// interface into the indirect management device space, one per cycle.
`timescale 1ns/100ps
`default_nettype none

module wol_event_enable_regs (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    // Register access
    input  wire wake_regs_pkg::reg_req_t     i_req,
    output logic                             o_rd_valid,
    output logic      [15:0]                 o_rd_data,
    // Toward frame matching
    output var wake_regs_pkg::wake_enable_t  o_enables,
    output logic      [47:0]                 o_dest_addr
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic reg_hit(input wake_regs_pkg::reg_req_t req,
                                     input logic [15:0] offset);
        reg_hit = (req.device == wake_regs_pkg::WAKE_DEVICE_ADDR) &&
                  (req.reg_addr == offset);
    endfunction

    logic wr_ctrl;
    logic wr_low;
    logic wr_mid;
    logic wr_high;

    assign wr_ctrl = i_req.write && reg_hit(i_req, wake_regs_pkg::OFF_EVENT_CONTROL);
    assign wr_low  = i_req.write && reg_hit(i_req, wake_regs_pkg::OFF_ADDR_LOW);
    assign wr_mid  = i_req.write && reg_hit(i_req, wake_regs_pkg::OFF_ADDR_MID);
    assign wr_high = i_req.write && reg_hit(i_req, wake_regs_pkg::OFF_ADDR_HIGH);

    ////////////////////////////////////////////////////////////////////////
    // Register words

    logic [15:0] ctrl_word;
    logic [15:0] low_word;
    logic [15:0] mid_word;
    logic [15:0] high_word;

    wake_word_reg #(
        .RESET_VALUE (wake_regs_pkg::RESET_EVENT_CONTROL)
    ) u_ctrl (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_wr_en   (wr_ctrl),
        .i_wr_data (i_req.wdata),
        .o_word    (ctrl_word)
    );

    wake_word_reg #(
        .RESET_VALUE (wake_regs_pkg::RESET_ADDR_WORD)
    ) u_low (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_wr_en   (wr_low),
        .i_wr_data (i_req.wdata),
        .o_word    (low_word)
    );

    wake_word_reg #(
        .RESET_VALUE (wake_regs_pkg::RESET_ADDR_WORD)
    ) u_mid (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_wr_en   (wr_mid),
        .i_wr_data (i_req.wdata),
        .o_word    (mid_word)
    );

    wake_word_reg #(
        .RESET_VALUE (wake_regs_pkg::RESET_ADDR_WORD)
    ) u_high (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_wr_en   (wr_high),
        .i_wr_data (i_req.wdata),
        .o_word    (high_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Static outputs

    always_comb begin
        o_enables.custom2      = ctrl_word[wake_regs_pkg::BIT_CUSTOM2];
        o_enables.custom1      = ctrl_word[wake_regs_pkg::BIT_CUSTOM1];
        o_enables.custom0      = ctrl_word[wake_regs_pkg::BIT_CUSTOM0];
        o_enables.link_down    = ctrl_word[wake_regs_pkg::BIT_LINK_DOWN];
        o_enables.link_up      = ctrl_word[wake_regs_pkg::BIT_LINK_UP];
        o_enables.remote_frame = ctrl_word[wake_regs_pkg::BIT_REMOTE_FRAME];
    end

    assign o_dest_addr = {high_word, mid_word, low_word};

    ////////////////////////////////////////////////////////////////////////
    // Read path

    typedef struct packed {
        logic        rd_valid;
        logic [15:0] rd_data;
    } read_state_t;

    read_state_t state_reg;
    read_state_t state_next;

    always_comb begin
        state_next          = state_reg;
        state_next.rd_valid = i_req.read;
        if (i_req.read) begin
            if (reg_hit(i_req, wake_regs_pkg::OFF_EVENT_CONTROL)) begin
                state_next.rd_data = ctrl_word;
            end else if (reg_hit(i_req, wake_regs_pkg::OFF_ADDR_LOW)) begin
                state_next.rd_data = low_word;
            end else if (reg_hit(i_req, wake_regs_pkg::OFF_ADDR_MID)) begin
                state_next.rd_data = mid_word;
            end else if (reg_hit(i_req, wake_regs_pkg::OFF_ADDR_HIGH)) begin
                state_next.rd_data = high_word;
            end else begin
                state_next.rd_data = wake_regs_pkg::RESET_READ_DATA;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg.rd_valid <= 1'b0;
            state_reg.rd_data  <= wake_regs_pkg::RESET_READ_DATA;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_valid = state_reg.rd_valid;
    assign o_rd_data  = state_reg.rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    type2_enable_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> o_enables.custom2 == $past(i_req.wdata[4]))
        else $error("custom type 2 enable does not follow bit 4");

    type1_enable_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> o_enables.custom1 == $past(i_req.wdata[3]))
        else $error("custom type 1 enable does not follow bit 3");

    type0_enable_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> o_enables.custom0 == $past(i_req.wdata[2]))
        else $error("custom type 0 enable does not follow bit 2");

    link_down_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> o_enables.link_down == $past(i_req.wdata[1]))
        else $error("link-down enable does not follow bit 1");

    link_up_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> o_enables.link_up == $past(i_req.wdata[0]))
        else $error("link-up enable does not follow bit 0");

    addr_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_low |=> o_dest_addr[15:0] == $past(i_req.wdata))
        else $error("low address word not placed at bits 15:0");

    addr_mid_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_mid |=> o_dest_addr[31:16] == $past(i_req.wdata))
        else $error("middle address word not placed at bits 31:16");

    remote_enable_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> o_enables.remote_frame == $past(i_req.wdata[6]))
        else $error("remote-wake enable does not follow bit 6");

    addr_high_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_high |=> o_dest_addr[47:32] == $past(i_req.wdata))
        else $error("high address word not placed at bits 47:32");

    outputs_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(wr_ctrl || wr_low || wr_mid || wr_high) |=> $stable(o_enables) && $stable(o_dest_addr))
        else $error("outputs changed without a write");

    read_back_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_low ##1 (i_req.read && reg_hit(i_req, wake_regs_pkg::OFF_ADDR_LOW) && !i_req.write)
        |=> o_rd_valid && o_rd_data == $past(i_req.wdata, 2))
        else $error("low word read-back mismatch");

    ctrl_store_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_ctrl |=> ctrl_word == $past(i_req.wdata))
        else $error("control word not stored in full");

    rd_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_rd_valid == $past(i_req.read))
        else $error("read valid is not a one-cycle answer");

    rd_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_req.read |=> $stable(o_rd_data))
        else $error("read data changed without a read");

    rd_old_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.read && reg_hit(i_req, wake_regs_pkg::OFF_ADDR_LOW)
        |=> o_rd_data == $past(low_word))
        else $error("low word read does not return the stored word");

    rd_unmapped_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.read && (i_req.device != wake_regs_pkg::WAKE_DEVICE_ADDR)
        |=> o_rd_data == wake_regs_pkg::RESET_READ_DATA)
        else $error("read of another device did not return zero");

endmodule

`default_nettype wire
